/* pgl_edge_det.sv */
// rising and falling edge detector for one synchronous level
`timescale 1ns/100ps
module pgl_edge_det (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic en_i,
  input  wire logic rst_val_i,
  input  wire logic sig_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_q;
  logic init_q;

  // first enabled cycle after reset loads the level without reporting an edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prev_q <= rst_val_i;
      init_q <= 1'b0;
    end else if (en_i) begin
      prev_q <= sig_i;
      init_q <= 1'b1;
    end
  end

  assign rise_o = en_i & init_q & sig_i & ~prev_q;
  assign fall_o = en_i & init_q & ~sig_i & prev_q;
endmodule : pgl_edge_det

/* pgl_glue.sv */
// power distribution, supply control, disk lamp and bus isolation glue
`timescale 1ns/100ps
module pgl_glue (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  input  wire logic                          main_supply_good_i,
  input  wire logic                          deep_sleep_n_i,
  input  wire logic                          soft_off_n_i,
  input  wire logic                          processor_inserted_n_i,
  input  wire logic                          thermal_trip_event_i,
  input  wire logic                          disk_act_first_n_i,
  input  wire logic                          disk_act_second_n_i,
  input  wire logic                          disk_act_scsi_n_i,
  output logic                               backfeed_cut_n_o,
  output logic                               held_regulator_switch_o,
  output logic                               main_supply_on_n_o,
  output logic                               disk_activity_lamp_n_o,
  output logic                               iso_clock_force_open_o,
  output logic                               iso_data_force_open_o,
  output logic                               trip_flag_o
);
  logic backfeed_cut_n_q;
  logic held_switch_q;
  logic held_switch_d;
  logic supply_on_n_q;
  logic lamp_n_q;
  logic iso_clk_q;
  logic iso_dat_q;
  logic trip_q;
  logic trip_d;
  wire  backfeed_cut_n_d;
  wire  supply_on_n_d;
  wire  lamp_n_d;
  wire  iso_open_d;
  wire  sleep_rise;
  wire  bkfd_rise;
  wire  bkfd_fall;
  wire  [pgl_pkg::DISK_INPUTS-1:0] disk_act_n;

  // low on any activity input means a drive is busy
  function automatic logic any_active(input logic [pgl_pkg::DISK_INPUTS-1:0] act_n);
    return ~(&act_n);
  endfunction : any_active

  assign backfeed_cut_n_d = ~(main_supply_good_i & deep_sleep_n_i);

  pgl_edge_det u_sleep_edge (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .en_i      (ce_i),
    .rst_val_i (pgl_pkg::RST_PREV_SLEEP),
    .sig_i     (deep_sleep_n_i),
    .rise_o    (sleep_rise),
    .fall_o    ()
  );

  pgl_edge_det u_bkfd_edge (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .en_i      (ce_i),
    .rst_val_i (pgl_pkg::RST_BKFD_N),
    .sig_i     (backfeed_cut_n_q),
    .rise_o    (bkfd_rise),
    .fall_o    (bkfd_fall)
  );

  always_comb begin
    held_switch_d = held_switch_q;
    if (!soft_off_n_i) begin
      held_switch_d = 1'b0;
    end else if (bkfd_rise) begin
      held_switch_d = 1'b1;
    end else if (bkfd_fall) begin
      held_switch_d = 1'b0;
    end
  end

  // set wins over clear when both occur together
  always_comb begin
    trip_d = trip_q;
    if (thermal_trip_event_i) begin
      trip_d = 1'b1;
    end else if (sleep_rise) begin
      trip_d = 1'b0;
    end
  end

  assign supply_on_n_d = ~(~processor_inserted_n_i & deep_sleep_n_i
                           & ~thermal_trip_event_i
                           & ~trip_d);

  assign disk_act_n = {disk_act_scsi_n_i, disk_act_second_n_i, disk_act_first_n_i};
  assign lamp_n_d   = ~any_active(disk_act_n);
  assign iso_open_d = ~main_supply_good_i;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      backfeed_cut_n_q <= pgl_pkg::RST_BKFD_N;
      held_switch_q    <= pgl_pkg::RST_HELD_SWITCH;
      supply_on_n_q    <= pgl_pkg::RST_SUPPLY_ON_N;
      lamp_n_q         <= pgl_pkg::RST_LAMP_N;
      iso_clk_q        <= pgl_pkg::RST_ISO_OPEN;
      iso_dat_q        <= pgl_pkg::RST_ISO_OPEN;
      trip_q           <= pgl_pkg::RST_TRIP_FLAG;
    end else if (ce_i) begin
      backfeed_cut_n_q <= backfeed_cut_n_d;
      held_switch_q    <= held_switch_d;
      supply_on_n_q    <= supply_on_n_d;
      lamp_n_q         <= lamp_n_d;
      iso_clk_q        <= iso_open_d;
      iso_dat_q        <= iso_open_d;
      trip_q           <= trip_d;
    end
  end

  assign backfeed_cut_n_o        = backfeed_cut_n_q;
  assign held_regulator_switch_o = held_switch_q;
  assign main_supply_on_n_o      = supply_on_n_q;
  assign disk_activity_lamp_n_o  = lamp_n_q;
  assign iso_clock_force_open_o  = iso_clk_q;
  assign iso_data_force_open_o   = iso_dat_q;
  assign trip_flag_o             = trip_q;

  property p_bkfd;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i |=> backfeed_cut_n_o == ~($past(main_supply_good_i) & $past(deep_sleep_n_i));
  endproperty
  a_bkfd: assert property (p_bkfd) else $error("backfeed cut wrong");

  property p_held_rise;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && soft_off_n_i && bkfd_rise) |=> held_regulator_switch_o;
  endproperty
  a_held_rise: assert property (p_held_rise) else $error("held switch not set");

  property p_held_off;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && !soft_off_n_i) |=> !held_regulator_switch_o;
  endproperty
  a_held_off: assert property (p_held_off) else $error("held switch not low");

  property p_on_needs_cpu;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && (processor_inserted_n_i || !deep_sleep_n_i)) |=> main_supply_on_n_o;
  endproperty
  a_on_needs_cpu: assert property (p_on_needs_cpu) else $error("supply on wrongly");

  property p_trip_off;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && thermal_trip_event_i) |=> main_supply_on_n_o;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("supply on during trip");

  property p_trip_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      trip_flag_o |-> main_supply_on_n_o;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("supply on after trip");

  property p_lamp;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && any_active(disk_act_n)) |=> !disk_activity_lamp_n_o;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not lit");

  property p_iso;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && !main_supply_good_i) |=> (iso_clock_force_open_o && iso_data_force_open_o);
  endproperty
  a_iso: assert property (p_iso) else $error("isolation not open");

  property p_trip_set;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && thermal_trip_event_i) |=> trip_flag_o;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip flag not set");

  property p_held_fall;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && soft_off_n_i && bkfd_fall) |=> !held_regulator_switch_o;
  endproperty
  a_held_fall: assert property (p_held_fall) else $error("held switch not cleared");

  property p_lamp_off;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && !any_active(disk_act_n)) |=> disk_activity_lamp_n_o;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while idle");

  property p_iso_close;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && main_supply_good_i) |=> !(iso_clock_force_open_o || iso_data_force_open_o);
  endproperty
  a_iso_close: assert property (p_iso_close) else $error("isolation stuck open");

  property p_trip_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && sleep_rise && !thermal_trip_event_i) |=> !trip_flag_o;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("trip flag not cleared");

  // clock enable low freezes every output
  property p_freeze;
    @(posedge clk_i) disable iff (!rstn_i)
      !ce_i |=> $stable({backfeed_cut_n_o, held_regulator_switch_o, main_supply_on_n_o,
                         disk_activity_lamp_n_o, iso_clock_force_open_o,
                         iso_data_force_open_o, trip_flag_o});
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");

  c_supply_on: cover property (@(posedge clk_i) disable iff (!rstn_i) !main_supply_on_n_o);
  c_held_set:  cover property (@(posedge clk_i) disable iff (!rstn_i) held_regulator_switch_o);
  c_trip_clr:  cover property (@(posedge clk_i) disable iff (!rstn_i) trip_flag_o ##[1:20] !trip_flag_o);
  c_held_clr:  cover property (@(posedge clk_i) disable iff (!rstn_i)
                               held_regulator_switch_o ##1 !held_regulator_switch_o);
endmodule : pgl_glue

/* pgl_pkg.sv */
// constants for the power glue logic block
package pgl_pkg;
  localparam logic RST_HELD_SWITCH = 1'b0;
  localparam logic RST_TRIP_FLAG   = 1'b0;
  localparam logic RST_SUPPLY_ON_N = 1'b1;
  localparam logic RST_BKFD_N      = 1'b1;
  localparam logic RST_LAMP_N      = 1'b1;
  localparam logic RST_ISO_OPEN    = 1'b1;
  localparam logic RST_PREV_SLEEP  = 1'b0;
  localparam int   DISK_INPUTS     = 3;
endpackage : pgl_pkg

/* pgl_sleep_model.sv */
// chipset sleep and main supply model with slow random level changes
`timescale 1ns/100ps
module pgl_sleep_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      good_o,
  output logic      sleep_n_o,
  output logic      soft_n_o
);
  // levels only move now and then so edges stay apart
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      good_o    <= 1'b0;
      sleep_n_o <= 1'b0;
      soft_n_o  <= 1'b0;
    end else begin
      good_o    <= ($urandom_range(7) == 0) ? ~good_o : good_o;
      sleep_n_o <= ($urandom_range(7) == 0) ? ~sleep_n_o : sleep_n_o;
      soft_n_o  <= ($urandom_range(15) == 0) ? ~soft_n_o : soft_n_o;
    end
  end
endmodule : pgl_sleep_model

/* tb_pgl_glue.sv */
// self-checking bench for the power glue block against a behavioural model
`timescale 1ns/100ps
module tb_pgl_glue;
  logic       clk_i  = 1'b0;
  logic       rstn_i = 1'b0;
  logic       ce_i   = 1'b1;
  logic       proc_n = 1'b0;
  logic       trip   = 1'b0;
  logic [2:0] act_n  = 3'h7;
  logic       good, sleep_n, soft_n, bk_n, held, on_n, lamp_n, iso_c, iso_d, flag;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         m_bk, m_pbk, m_held, m_flag, m_ps, m_on, m_lamp, m_iso;
  always #2 clk_i = ~clk_i;
  pgl_sleep_model i_pgl_sleep_model (.clk_i(clk_i), .rstn_i(rstn_i), .good_o(good),
    .sleep_n_o(sleep_n), .soft_n_o(soft_n));
  pgl_glue i_pgl_glue (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .main_supply_good_i(good), .deep_sleep_n_i(sleep_n), .soft_off_n_i(soft_n),
    .processor_inserted_n_i(proc_n), .thermal_trip_event_i(trip),
    .disk_act_first_n_i(act_n[0]), .disk_act_second_n_i(act_n[1]),
    .disk_act_scsi_n_i(act_n[2]), .backfeed_cut_n_o(bk_n), .held_regulator_switch_o(held),
    .main_supply_on_n_o(on_n), .disk_activity_lamp_n_o(lamp_n),
    .iso_clock_force_open_o(iso_c), .iso_data_force_open_o(iso_d), .trip_flag_o(flag));
  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // model steps on the inputs seen before this edge
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      {m_bk, m_pbk, m_on, m_lamp, m_iso} = {5{32'h1}};
      {m_held, m_flag, m_ps} = {3{32'h0}};
    end else if (ce_i) begin
      m_held = !soft_n ? 0 : (m_bk && !m_pbk) ? 1 : (!m_bk && m_pbk) ? 0 : m_held;
      m_pbk = m_bk;
      m_bk = !(good && sleep_n);
      m_flag = trip ? 1 : (sleep_n && !m_ps) ? 0 : m_flag;
      m_on = !(!proc_n && sleep_n && !trip && !m_flag);
      m_ps = sleep_n;
      m_lamp = &act_n;
      m_iso = !good;
    end
  end
  initial begin
    @(posedge clk_i);
    forever begin
      @(negedge clk_i);
      check(bk_n, m_bk[0]);
      check(held, m_held[0]);
      check(lamp_n, m_lamp[0]);
      check(iso_c, m_iso[0]);
      check(iso_d, m_iso[0]);
      check(flag, m_flag[0]);
      check(on_n, m_on[0]);
    end
  end
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ce_i   <= ($urandom_range(15) != 0);
      proc_n <= ($urandom_range(31) == 0) ? ~proc_n : proc_n;
      trip   <= ($urandom_range(63) == 0);
      act_n  <= ($urandom_range(3) != 0) ? 3'h7 : 3'($urandom);
    end
  endtask : run
  initial begin
    void'($urandom(32'h4af4));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    run(4000);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    rstn_i <= 1'b1;
    run(4000);
    final_report();
  end
  initial begin
    #40000;
    miscompares++;
    final_report();
  end
endmodule : tb_pgl_glue
